// >>> logic/clock_ctrl.v
// Oscillator stop control and CPU/peripheral clock source selection.
// Assumes AXI4-Lite master on aclk; oscillator and option inputs asynchronous.
`default_nettype none
`include "clock_ctrl_consts.vh"

// Summary of operation
// (RQ1) Stop instruction enters stop, halts internal oscillator
// (RQ2) Software loads stabilization time before crystal stop
// (RQ3) Status bit: 0 internal, 1 system clock
// (RQ4) Writing 1 to stop bit halts internal oscillator
// (RQ5) Software confirms status 1 before internal stop
// (RQ6) Low-speed clock never feeds CPU
// (RQ7) Option chooses always-on or stoppable low-speed
// (RQ8) Low-speed starts at reset, ticks watchdog 240 kHz
// (RQ9) Low-speed stop bit halts, clearing restarts
// (RQ10) Always-on option makes low-speed stop bit inert
// (RQ11) Select bit 2, mode bit 0, external bit 7
// (RQ12) Select 0 forces internal clock everywhere
// (RQ13) Select 1 mode 0: CPU internal, peripherals external; code uses crystal unless external bit 7 set
// (RQ14) Select 1 mode 1: all on system clock
// (RQ15) Reset leaves CPU on internal oscillator
// (RQ16) Software sequence to reach system clock
// (RQ17) Select bit changes once per reset
// (RQ18) Internal stop bit 0, stable flag bit 7
// (RQ19) Switch without runt pulses, status follows mux
module clock_ctrl (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        stop_execute,
  input  wire        wake_event,
  input  wire        ls_option_always_on,
  input  wire        wdt_option_enable,
  input  wire        timer8_ls_select,
  input  wire        hs_osc_ready,
  input  wire [7:0]  osc_stabilization_counter,
  output wire        hs_osc_enable,
  output wire        ls_osc_enable,
  output wire        crystal_osc_enable,
  output wire        external_clock_input_enable,
  output wire        cpu_clock_sel,
  output wire [1:0]  periph_clock_sel,
  output reg         wdt_clock_tick,
  output reg         timer8_clock_tick,
  output reg         stop_mode
);
  localparam integer LS_DIV_FULL = `LS_DIV_CYCLES - 1;
  localparam [9:0]   LS_DIV_LAST = LS_DIV_FULL[9:0];

  // Address decode shared by read and write paths
  function [2:0] reg_index;
    input [7:0] addr;
    begin
      if (addr == `OFS_MAIN_CLOCK_MODE)
        reg_index = `IDX_MAIN_CLOCK_MODE;
      else if (addr == `OFS_CLOCK_OP_MODE)
        reg_index = `IDX_CLOCK_OP_MODE;
      else if (addr == `OFS_INTERNAL_OSC_MODE)
        reg_index = `IDX_INTERNAL_OSC_MODE;
      else if (addr == `OFS_MAIN_OSC_CTRL)
        reg_index = `IDX_MAIN_OSC_CTRL;
      else if (addr == `OFS_OSC_STAB_SELECT)
        reg_index = `IDX_OSC_STAB_SELECT;
      else if (addr == `OFS_OSC_STAB_COUNTER)
        reg_index = `IDX_OSC_STAB_COUNTER;
      else
        reg_index = `IDX_NONE;
    end
  endfunction

  // Control bits
  reg        clock_source_select;
  reg        select_locked;
  reg        main_clock_mode_bit;
  reg        external_clock_enable;
  reg        oscillator_mode_bit;
  reg        hs_osc_stop;
  reg        ls_osc_stop;
  reg        main_osc_stop;
  reg [2:0]  osc_stabilization_time_select;

  // Input synchronisers
  reg [1:0]  sync_wake;
  reg [1:0]  sync_ls_opt;
  reg [1:0]  sync_wdt_opt;
  reg [1:0]  sync_hs_ready;
  reg [7:0]  stab_meta;
  reg [7:0]  stab_second;
  reg [7:0]  stab_third;
  reg [7:0]  stab_sync;

  always @(posedge aclk) begin
    if (!aresetn) begin
      sync_wake     <= 2'h0;
      sync_ls_opt   <= 2'h0;
      sync_wdt_opt  <= 2'h0;
      sync_hs_ready <= 2'h0;
      stab_meta     <= 8'h00;
      stab_second   <= 8'h00;
      stab_third    <= 8'h00;
      stab_sync     <= 8'h00;
    end else begin
      sync_wake     <= {sync_wake[0], wake_event};
      sync_ls_opt   <= {sync_ls_opt[0], ls_option_always_on};
      sync_wdt_opt  <= {sync_wdt_opt[0], wdt_option_enable};
      sync_hs_ready <= {sync_hs_ready[0], hs_osc_ready};
      stab_meta     <= osc_stabilization_counter;
      stab_second   <= stab_meta;
      stab_third    <= stab_second;
      // Counter word taken only when two samples agree
      if (stab_second == stab_third)
        stab_sync   <= stab_second;
    end
  end

  wire wake_s     = sync_wake[1];
  wire ls_always  = sync_ls_opt[1];
  wire wdt_opt    = sync_wdt_opt[1];
  wire hs_ready_s = sync_hs_ready[1];

  // AXI write channel
  reg        aw_held;
  reg [7:0]  aw_addr;
  reg        w_held;
  reg [31:0] w_data;
  reg [3:0]  w_strb;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  wire       aw_fire = s_axi_awvalid && s_axi_awready;
  wire       w_fire  = s_axi_wvalid && s_axi_wready;
  wire       have_aw = aw_held || aw_fire;
  wire       have_w  = w_held || w_fire;
  wire       do_write = have_aw && have_w && !s_axi_bvalid;
  wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire [2:0] wr_idx  = reg_index(wr_addr);
  wire       wr_lane = do_write && wr_strb[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      aw_addr      <= 8'h00;
      w_held       <= 1'b0;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wr_idx == `IDX_NONE)
          s_axi_bresp <= `RESP_SLVERR;
        else
          s_axi_bresp <= `RESP_OKAY;
      end else begin
        if (aw_fire) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (w_fire) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes
  wire new_select = wr_data[`BIT_SOURCE_SELECT];
  wire wr_mcm     = wr_lane && (wr_idx == `IDX_MAIN_CLOCK_MODE);

  always @(posedge aclk) begin
    if (!aresetn) begin
      clock_source_select           <= 1'b0; // RQ15
      select_locked                 <= 1'b0;
      main_clock_mode_bit           <= 1'b0;
      external_clock_enable         <= 1'b0;
      oscillator_mode_bit           <= 1'b0;
      hs_osc_stop                   <= 1'b0;
      ls_osc_stop                   <= 1'b0; // RQ8
      main_osc_stop                 <= `RST_MAIN_OSC_STOP;
      osc_stabilization_time_select <= `RST_OSC_STAB_SELECT;
    end else begin
      if (wr_mcm) begin
        main_clock_mode_bit <= wr_data[`BIT_MAIN_MODE]; // RQ11
        if (!select_locked && new_select != clock_source_select) begin
          clock_source_select <= new_select; // RQ17
          select_locked       <= 1'b1; // RQ17
        end
      end
      if (wr_lane && wr_idx == `IDX_CLOCK_OP_MODE) begin
        external_clock_enable <= wr_data[`BIT_EXT_ENABLE]; // RQ11
        oscillator_mode_bit   <= wr_data[`BIT_OSC_MODE];
      end
      if (wr_lane && wr_idx == `IDX_INTERNAL_OSC_MODE) begin
        hs_osc_stop <= wr_data[`BIT_HS_STOP]; // RQ4
        ls_osc_stop <= wr_data[`BIT_LS_STOP]; // RQ9
      end
      if (wr_lane && wr_idx == `IDX_MAIN_OSC_CTRL)
        main_osc_stop <= wr_data[`BIT_MAIN_OSC_STOP];
      if (wr_lane && wr_idx == `IDX_OSC_STAB_SELECT)
        osc_stabilization_time_select <= wr_data[`STAB_SEL_MSB:0];
    end
  end

  // Stop mode: entered by the stop instruction, left on a wake event
  always @(posedge aclk) begin
    if (!aresetn)
      stop_mode <= 1'b0;
    else if (stop_execute)
      stop_mode <= 1'b1; // RQ1
    else if (wake_s)
      stop_mode <= 1'b0;
  end

  // Oscillator enables
  assign hs_osc_enable = !hs_osc_stop && !stop_mode; // RQ1 RQ4
  assign ls_osc_enable = ls_always || !ls_osc_stop; // RQ7 RQ9 RQ10
  wire   hs_sys_run    = oscillator_mode_bit && !main_osc_stop && !stop_mode;
  assign crystal_osc_enable          = hs_sys_run && !external_clock_enable;
  assign external_clock_input_enable = hs_sys_run && external_clock_enable;

  wire hs_osc_stable_flag = hs_ready_s && hs_osc_enable;

  // Requested sources; the low-speed clock has no code here
  reg  [1:0] cpu_request;
  reg  [1:0] periph_request;
  wire [1:0] cpu_current;
  wire [1:0] ext_src = external_clock_enable ? `PSRC_EXTERNAL
                                             : `PSRC_CRYSTAL;

  always @* begin
    if (!clock_source_select) begin
      cpu_request    = 2'h0; // RQ12
      periph_request = `PSRC_INTERNAL; // RQ12
    end else if (!main_clock_mode_bit) begin
      cpu_request    = 2'h0; // RQ13
      periph_request = ext_src; // RQ13
    end else begin
      cpu_request    = 2'h1; // RQ14 RQ6
      periph_request = ext_src; // RQ14
    end
  end

  clock_switch cpu_switch (
    .aclk    (aclk),
    .aresetn (aresetn),
    .request (cpu_request),
    .current (cpu_current),
    .busy    ()
  );

  clock_switch periph_switch (
    .aclk    (aclk),
    .aresetn (aresetn),
    .request (periph_request),
    .current (periph_clock_sel),
    .busy    ()
  );

  assign cpu_clock_sel = cpu_current[0]; // RQ19
  wire cpu_clock_source_status = cpu_current[0]; // RQ3 RQ19

  // Low-speed tick divider; only the watchdog and 8-bit timer take it
  reg [9:0] ls_div;
  wire      ls_wrap = (ls_div == LS_DIV_LAST);

  always @(posedge aclk) begin
    if (!aresetn) begin
      ls_div            <= 10'h000;
      wdt_clock_tick    <= 1'b0;
      timer8_clock_tick <= 1'b0;
    end else begin
      if (!ls_osc_enable || ls_wrap)
        ls_div <= 10'h000;
      else
        ls_div <= ls_div + 10'h001;
      wdt_clock_tick    <= ls_osc_enable && ls_wrap && wdt_opt; // RQ8 RQ6
      timer8_clock_tick <= ls_osc_enable && ls_wrap && timer8_ls_select;
    end
  end

  // AXI read channel
  reg [31:0] rd_word;
  wire [2:0] rd_idx = reg_index(s_axi_araddr);
  assign s_axi_arready = !s_axi_rvalid;

  always @* begin
    rd_word = 32'h00000000;
    if (rd_idx == `IDX_MAIN_CLOCK_MODE) begin
      rd_word[`BIT_SOURCE_SELECT] = clock_source_select;
      rd_word[`BIT_CPU_STATUS]    = cpu_clock_source_status; // RQ3
      rd_word[`BIT_MAIN_MODE]     = main_clock_mode_bit;
    end else if (rd_idx == `IDX_CLOCK_OP_MODE) begin
      rd_word[`BIT_EXT_ENABLE] = external_clock_enable;
      rd_word[`BIT_OSC_MODE]   = oscillator_mode_bit;
    end else if (rd_idx == `IDX_INTERNAL_OSC_MODE) begin
      rd_word[`BIT_HS_STABLE] = hs_osc_stable_flag; // RQ18
      rd_word[`BIT_LS_STOP]   = ls_osc_stop;
      rd_word[`BIT_HS_STOP]   = hs_osc_stop; // RQ18
    end else if (rd_idx == `IDX_MAIN_OSC_CTRL) begin
      rd_word[`BIT_MAIN_OSC_STOP] = main_osc_stop;
    end else if (rd_idx == `IDX_OSC_STAB_SELECT) begin
      rd_word[`STAB_SEL_MSB:0] = osc_stabilization_time_select;
    end else if (rd_idx == `IDX_OSC_STAB_COUNTER) begin
      rd_word[`STAB_CNT_MSB:0] = stab_sync;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      if (rd_idx == `IDX_NONE)
        s_axi_rresp <= `RESP_SLVERR;
      else
        s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // clock_ctrl

`default_nettype wire

// >>> logic/clock_ctrl_consts.vh
// Constants for the oscillator stop and clock select block.
// Assumes a 200 MHz aclk and 32-bit AXI4-Lite register access.
`ifndef CLOCK_CTRL_CONSTS_VH
`define CLOCK_CTRL_CONSTS_VH

// Register byte offsets
`define OFS_MAIN_CLOCK_MODE    8'h00
`define OFS_CLOCK_OP_MODE      8'h04
`define OFS_INTERNAL_OSC_MODE  8'h08
`define OFS_MAIN_OSC_CTRL      8'h0c
`define OFS_OSC_STAB_SELECT    8'h10
`define OFS_OSC_STAB_COUNTER   8'h14

// Decoded register indices
`define IDX_MAIN_CLOCK_MODE    3'h0
`define IDX_CLOCK_OP_MODE      3'h1
`define IDX_INTERNAL_OSC_MODE  3'h2
`define IDX_MAIN_OSC_CTRL      3'h3
`define IDX_OSC_STAB_SELECT    3'h4
`define IDX_OSC_STAB_COUNTER   3'h5
`define IDX_NONE               3'h7

// Field positions
`define BIT_SOURCE_SELECT      2
`define BIT_CPU_STATUS         1
`define BIT_MAIN_MODE          0
`define BIT_EXT_ENABLE         7
`define BIT_OSC_MODE           6
`define BIT_HS_STOP            0
`define BIT_LS_STOP            1
`define BIT_HS_STABLE          7
`define BIT_MAIN_OSC_STOP      7
`define STAB_SEL_MSB           2
`define STAB_CNT_MSB           7

// Reset values
`define RST_MAIN_OSC_STOP      1'b1
`define RST_OSC_STAB_SELECT    3'h7

// AXI responses
`define RESP_OKAY              2'b00
`define RESP_SLVERR            2'b10

// Peripheral clock source codes
`define PSRC_INTERNAL          2'h0
`define PSRC_CRYSTAL           2'h1
`define PSRC_EXTERNAL          2'h2

// Timing
`define SWITCH_CYCLES          3'h4
`define CLK_RATE_KHZ           200000
`define LS_RATE_KHZ            240
`define LS_DIV_CYCLES          (`CLK_RATE_KHZ / `LS_RATE_KHZ)

`endif

// >>> logic/clock_switch.v
// Glitch-free source switch: moves the selected source after a settle time.
// Assumes request comes from logic on aclk.
`default_nettype none
`include "clock_ctrl_consts.vh"

module clock_switch (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire [1:0] request,
  output reg  [1:0] current,
  output wire       busy
);
  reg [2:0] settle;

  assign busy = (request != current);

  // Old source is held until the settle count ends, then swapped at once
  always @(posedge aclk) begin
    if (!aresetn) begin
      current <= 2'h0;
      settle  <= 3'h0;
    end else if (request == current) begin
      settle <= 3'h0;
    end else if (settle == `SWITCH_CYCLES - 3'h1) begin
      current <= request; // RQ19
      settle  <= 3'h0;
    end else begin
      settle <= settle + 3'h1;
    end
  end
endmodule // clock_switch

`default_nettype wire

// >>> testbench/clock_ctrl_checker.sv
// Checker for the clock control block, bound to its top module.
// Assumes it sees only the ports of clock_ctrl.
`default_nettype none
module clock_ctrl_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic stop_execute,
  input wire logic stop_mode,
  input wire logic hs_osc_enable,
  input wire logic crystal_osc_enable,
  input wire logic external_clock_input_enable,
  input wire logic ls_osc_enable,
  input wire logic ls_option_always_on,
  input wire logic wdt_option_enable,
  input wire logic wdt_clock_tick,
  input wire logic cpu_clock_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] gap;
  logic       seen;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Cycles since the last watchdog tick
  always @(posedge aclk) begin
    if (!aresetn || !ls_osc_enable || !wdt_option_enable) begin
      gap <= 10'h000;
      seen <= 1'b0;
    end else if (wdt_clock_tick) begin
      gap <= 10'h000;
      seen <= 1'b1;
    end else begin
      gap <= gap + 10'h001;
    end
  end
  chk_stop_entry: assert property (
    stop_execute |=> stop_mode) else $error("stop mode not entered");
  chk_stop_halts: assert property (
    stop_mode |-> !hs_osc_enable && !crystal_osc_enable &&
    !external_clock_input_enable) else $error("oscillator runs in stop");
  chk_ls_always_on: assert property (
    ls_option_always_on [*4] |-> ls_osc_enable)
    else $error("low-speed stopped while always on");
  chk_ls_stop_tick: assert property (
    !ls_osc_enable [*2] |-> !wdt_clock_tick)
    else $error("tick while low-speed stopped");
  chk_wdt_period: assert property (
    wdt_clock_tick && seen |-> gap == 10'h340)
    else $error("watchdog tick period wrong");
  chk_switch_delay: assert property (
    $changed(cpu_clock_sel) |->
    $past(s_axi_bvalid, 4) || $past(s_axi_bvalid, 5))
    else $error("cpu source moved without a write");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_one_main_src: assert property (
    !(crystal_osc_enable && external_clock_input_enable))
    else $error("crystal and external both enabled");
endmodule // clock_ctrl_checker
bind clock_ctrl clock_ctrl_checker chk_i (.*);
`default_nettype wire

// >>> testbench/tb_clock_ctrl.sv
// Testbench for the clock control block, register access over AXI4-Lite.
// Assumes the design files and the checker are compiled first.
`default_nettype none
module tb_clock_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, stop_execute = 1'b0;
  logic wake_event = 1'b0, timer8_ls_select = 1'b0, hs_osc_ready = 1'b1;
  logic ls_option_always_on = 1'b0, wdt_option_enable = 1'b1;
  logic [7:0] osc_stabilization_counter = 8'h5a;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, hs_osc_enable, ls_osc_enable, crystal_osc_enable;
  logic external_clock_input_enable, cpu_clock_sel, wdt_clock_tick;
  logic timer8_clock_tick, stop_mode;
  logic [1:0] s_axi_bresp, s_axi_rresp, periph_clock_sel;
  logic [31:0] s_axi_rdata;
  int num_errors = 0;
  int checks_done = 0;
  int n;
  clock_ctrl dut (.*);
  always #2.5 aclk = ~aclk;
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end while (aw || w);
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    chk($sformatf("bresp %h", a), er, s_axi_bresp);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    chk($sformatf("rdata %h", a), e, s_axi_rdata);
    chk($sformatf("rresp %h", a), er, s_axi_rresp);
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("cpu_sel", 1'b0, cpu_clock_sel);
    chk("periph_sel", 2'h0, periph_clock_sel);
    chk("ls_en", 1'b1, ls_osc_enable);
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h08, 32'h80, 2'h0);
    rd(8'h0c, 32'h80, 2'h0);
    rd(8'h10, 32'h7, 2'h0);
    rd(8'h14, 32'h5a, 2'h0);
    rd(8'h18, 32'h0, 2'h2);
    wr(8'h18, 32'hff, 2'h2);
    wr(8'h08, 32'h02, 2'h0);
    repeat (4) @(posedge aclk);
    chk("ls_en", 1'b0, ls_osc_enable);
    chk("hs_en", 1'b1, hs_osc_enable);
    rd(8'h08, 32'h82, 2'h0);
    ls_option_always_on <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("ls_en", 1'b1, ls_osc_enable);
    ls_option_always_on <= 1'b0;
    wr(8'h08, 32'h00, 2'h0);
    repeat (4) @(posedge aclk);
    chk("ls_en", 1'b1, ls_osc_enable);
    while (wdt_clock_tick !== 1'b1) @(posedge aclk);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (wdt_clock_tick !== 1'b1);
    chk("wdt_gap", 32'h341, n);
    timer8_ls_select <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (timer8_clock_tick !== 1'b1 && n < 900);
    chk("timer8", 1'b1, timer8_clock_tick);
    wr(8'h00, 32'h01, 2'h0);
    wr(8'h04, 32'h40, 2'h0);
    wr(8'h0c, 32'h00, 2'h0);
    repeat (6) @(posedge aclk);
    chk("cpu_sel", 1'b0, cpu_clock_sel);
    chk("periph_sel", 2'h0, periph_clock_sel);
    chk("xtal_en", 1'b1, crystal_osc_enable);
    rd(8'h14, 32'h5a, 2'h0);
    wr(8'h00, 32'h04, 2'h0);
    repeat (6) @(posedge aclk);
    chk("cpu_sel", 1'b0, cpu_clock_sel);
    chk("periph_sel", 2'h1, periph_clock_sel);
    wr(8'h04, 32'hc0, 2'h0);
    repeat (6) @(posedge aclk);
    chk("periph_sel", 2'h2, periph_clock_sel);
    chk("ext_en", 1'b1, external_clock_input_enable);
    wr(8'h00, 32'h05, 2'h0);
    repeat (6) @(posedge aclk);
    chk("cpu_sel", 1'b1, cpu_clock_sel);
    rd(8'h00, 32'h07, 2'h0);
    wr(8'h04, 32'h40, 2'h0);
    repeat (6) @(posedge aclk);
    chk("periph_sel", 2'h1, periph_clock_sel);
    rd(8'h00, 32'h07, 2'h0);
    wr(8'h08, 32'h01, 2'h0);
    repeat (4) @(posedge aclk);
    chk("hs_en", 1'b0, hs_osc_enable);
    rd(8'h08, 32'h01, 2'h0);
    wr(8'h00, 32'h01, 2'h0);
    repeat (6) @(posedge aclk);
    rd(8'h00, 32'h07, 2'h0);
    chk("cpu_sel", 1'b1, cpu_clock_sel);
    wr(8'h08, 32'h00, 2'h0);
    chk("hs_en", 1'b1, hs_osc_enable);
    hs_osc_ready <= 1'b0;
    repeat (3) @(posedge aclk);
    rd(8'h08, 32'h00, 2'h0);
    hs_osc_ready <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(8'h08, 32'h80, 2'h0);
    wr(8'h10, 32'h03, 2'h0);
    rd(8'h10, 32'h03, 2'h0);
    stop_execute <= 1'b1;
    @(posedge aclk);
    stop_execute <= 1'b0;
    @(posedge aclk);
    chk("stop", 1'b1, stop_mode);
    chk("hs_en", 1'b0, hs_osc_enable);
    chk("xtal_en", 1'b0, crystal_osc_enable);
    wake_event <= 1'b1;
    repeat (5) @(posedge aclk);
    wake_event <= 1'b0;
    chk("stop", 1'b0, stop_mode);
    chk("xtal_en", 1'b1, crystal_osc_enable);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("cpu_sel", 1'b0, cpu_clock_sel);
    rd(8'h00, 32'h00, 2'h0);
    wr(8'h00, 32'h04, 2'h0);
    rd(8'h00, 32'h04, 2'h0);
    final_report;
  end
  // Cuts a hang short
  initial begin
    #100000;
    num_errors++;
    final_report;
  end
endmodule // tb_clock_ctrl
`default_nettype wire
